/* File: src/mfvc_pkg.sv */
// Package with offsets, field positions and reset values of the MAC config group.
`default_nettype none
package mfvc_pkg;
    localparam logic [4:0] OFF_JAM_LIMIT   = 5'h17;
    localparam logic [4:0] OFF_FLOW_CTRL   = 5'h1a;
    localparam logic [4:0] OFF_MAC_CONFIG  = 5'h1b;
    localparam logic [4:0] OFF_TAG_LOW     = 5'h1c;
    localparam logic [4:0] OFF_TAG_HIGH    = 5'h1d;
    localparam logic [4:0] OFF_BYTE_ORDER  = 5'h1e;
    localparam logic [4:0] OFF_HOST_WAKE   = 5'h1f;
    // Flow control register fields.
    localparam int FC_ENABLE_BIT   = 7;
    localparam int FC_BP_BIT       = 6;
    // MAC configuration fields, then the 1CH queue full and 1FH wake bits.
    localparam int MC_DUPLEX_BIT   = 7;
    localparam int MC_LEAK_DIS_BIT = 6;
    localparam int MC_B2B_BIT      = 5;
    localparam int MC_MEDIA_BIT    = 4;
    localparam int MC_TAG_BIT      = 3;
    localparam int MC_CAPTURE_BIT  = 2;
    localparam int MC_SHORT_BIT    = 1;
    localparam int MC_ZERO_BIT     = 0;
    localparam int TX_FULL_BIT     = 7;
    localparam int WAKE_BIT        = 0;
    // Reset values.
    localparam logic [7:0] RST_FLOW_CTRL  = 8'h07;
    localparam logic [7:0] RST_MAC_CONFIG = 8'h00;
    localparam logic [5:0] RST_JAM_LIMIT  = 6'h19;
    localparam logic [7:0] RST_TAG_LOW    = 8'h00;
    localparam logic [7:0] RST_TAG_HIGH   = 8'h00;
    localparam logic [7:0] RST_BYTE_ORDER = 8'h00;
    localparam logic [6:0] RST_END_PAGE   = 7'h00;
    // Back-off limits for the test modes, in slot times, and the VLAN tag type.
    localparam logic [9:0] BO_FIRST_CAPTURE = 10'h002;
    localparam logic [9:0] BO_SHORT_MASK    = 10'h003;
    localparam logic [15:0] TAG_TYPE_VLAN   = 16'h8100;
endpackage
`default_nettype wire

/* File: src/mfvc_backoff.sv */
// Back-off slot count shaping under the MAC test modes.
`default_nettype none
module mfvc_backoff (
    input  wire logic       capture_effect_test,
    input  wire logic       short_backoff_test,
    input  wire logic       zero_backoff_test,
    input  wire logic [4:0] attempt,
    input  wire logic [9:0] random_slots,
    output logic      [9:0] slots
);
    // Zero wins over the other test modes since it is the most restrictive.
    always_comb begin
        slots = random_slots;
        if (zero_backoff_test) begin
            slots = 10'h000;
        end else if (capture_effect_test && attempt == 5'h01) begin
            slots = mfvc_pkg::BO_FIRST_CAPTURE;
        end else if (capture_effect_test && attempt == 5'h02) begin
            slots = 10'h000;
        end else if (short_backoff_test) begin
            slots = random_slots & mfvc_pkg::BO_SHORT_MASK;
        end
    end
endmodule
`default_nettype wire

/* File: src/mfvc_tag_filter.sv */
// Receive tag filter that compares a frame tag with the programmed identifier.
`default_nettype none
module mfvc_tag_filter (
    input  wire logic        enable,
    input  wire logic        frame_tagged,
    input  wire logic [15:0] tag_type,
    input  wire logic [11:0] frame_id,
    input  wire logic [11:0] prog_id,
    output logic             accept
);
    // Untagged frames are dropped while filtering; a tagged frame with null id always passes.
    always_comb begin
        accept = 1'b1;
        if (enable) begin
            if (!frame_tagged) begin
                accept = 1'b0;
            end else if (tag_type == mfvc_pkg::TAG_TYPE_VLAN &&
                         frame_id != 12'h000 && frame_id != prog_id) begin
                accept = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/mfvc_regs.sv */
// Flow, MAC configuration, tag, byte order and wake register group.
// Notes on behaviour
// - Flow bit 7 enables flow control, reset off.
// - Flow bit 6 back pressure, ignored full duplex.
// - Flow bits 5:0 free page threshold, reset 7.
// - Duplex read shows real mode, OR with transmit.
// - Internal PHY ignores both duplex inputs.
// - Bit 6 clear leaks back pressure after jams.
// - Bit 5 accepts transmit starts before completion.
// - Bit 4 selects internal or external PHY.
// - Bit 3 filters tagged frames on identifier.
// - Bit 2 capture test: back-off 2 then 0.
// - Bit 1 limits back-off to 0..3 slots.
// - Bit 0 forces zero back-off.
// - 1DH writes priority, canonical flag, id high.
// - 1CH bit 7 reports transmit queue full.
// - End page updates on clean transmit, 00 reset.
// - Non-zero byte order selects big endian.
// - 1FH bit 0 wakes device, self-clears.
// - Reading 1FH triggers software reset.
// - Jam limit 6-bit write-only, reset 19H.
`default_nettype none
module mfvc_regs (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [4:0]  ADDR,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    input  wire logic [7:0]  WDATA,
    output logic      [7:0]  RDATA,
    input  wire logic        TX_CONFIG_FULL,
    input  wire logic        PHY_FULL_DUPLEX,
    input  wire logic        TX_QUEUE_FULL,
    input  wire logic        TX_DONE_OK,
    input  wire logic [6:0]  TX_END_PAGE,
    input  wire logic        STOP_CMD,
    input  wire logic        AWAKE,
    input  wire logic [5:0]  COLLISION_RUN,
    input  wire logic [4:0]  BO_ATTEMPT,
    input  wire logic [9:0]  BO_RANDOM,
    input  wire logic        RX_TAGGED,
    input  wire logic [15:0] RX_TAG_TYPE,
    input  wire logic [11:0] RX_TAG_ID,
    output logic             RX_ACCEPT,
    output logic [9:0]       BO_SLOTS,
    output logic             FLOW_CTRL_ENABLE,
    output logic             BACKPRESSURE_ACTIVE,
    output logic [5:0]       HIGH_WATER_FREE_PAGES,
    output logic             MAC_DUPLEX,
    output logic             BACK_TO_BACK_TX,
    output logic             MEDIA_SELECT,
    output logic [2:0]       FRAME_URGENCY_CLASS,
    output logic             CANONICAL_FORMAT_FLAG,
    output logic             BIG_ENDIAN,
    output logic             WAKE_REQUEST,
    output logic             SOFT_RESET
);
    logic [7:0]  flow_q;
    logic [7:0]  mcfg_q;
    logic [5:0]  jam_q;
    logic [7:0]  tag_low_q;
    logic [7:0]  tag_high_q;
    logic [7:0]  border_q;
    logic        wake_q;
    logic [6:0]  end_page_q;
    logic        soft_rst_q;
    logic        wr_flow;
    logic        wr_mcfg;
    logic        wr_jam;
    logic        wr_tlow;
    logic        wr_thigh;
    logic        wr_border;
    logic        wr_wake;
    logic        duplex_full;
    logic [7:0]  rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // Write decode; a single strobe cycle writes a register once.
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    assign wr_flow   = WR_STB && hit(ADDR, mfvc_pkg::OFF_FLOW_CTRL);
    assign wr_mcfg   = WR_STB && hit(ADDR, mfvc_pkg::OFF_MAC_CONFIG);
    assign wr_jam    = WR_STB && hit(ADDR, mfvc_pkg::OFF_JAM_LIMIT);
    assign wr_tlow   = WR_STB && hit(ADDR, mfvc_pkg::OFF_TAG_LOW);
    assign wr_thigh  = WR_STB && hit(ADDR, mfvc_pkg::OFF_TAG_HIGH);
    assign wr_border = WR_STB && hit(ADDR, mfvc_pkg::OFF_BYTE_ORDER);
    assign wr_wake   = WR_STB && hit(ADDR, mfvc_pkg::OFF_HOST_WAKE);

    ////////////////////////////////////////////////////////////////////////
    // Software reset pulse, one cycle after a read of the wake offset.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= RD_STB && hit(ADDR, mfvc_pkg::OFF_HOST_WAKE);
        end
    end
    assign SOFT_RESET = soft_rst_q;

    // Configuration registers; soft reset restores defaults, over any write.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flow_q     <= mfvc_pkg::RST_FLOW_CTRL;
            mcfg_q     <= mfvc_pkg::RST_MAC_CONFIG;
            jam_q      <= mfvc_pkg::RST_JAM_LIMIT;
            tag_low_q  <= mfvc_pkg::RST_TAG_LOW;
            tag_high_q <= mfvc_pkg::RST_TAG_HIGH;
            border_q   <= mfvc_pkg::RST_BYTE_ORDER;
        end else if (soft_rst_q) begin
            flow_q     <= mfvc_pkg::RST_FLOW_CTRL;
            mcfg_q     <= mfvc_pkg::RST_MAC_CONFIG;
            jam_q      <= mfvc_pkg::RST_JAM_LIMIT;
            tag_low_q  <= mfvc_pkg::RST_TAG_LOW;
            tag_high_q <= mfvc_pkg::RST_TAG_HIGH;
            border_q   <= mfvc_pkg::RST_BYTE_ORDER;
        end else begin
            if (wr_flow) begin
                flow_q <= WDATA;
            end
            if (wr_mcfg) begin
                mcfg_q <= WDATA;
            end
            if (wr_jam) begin
                jam_q <= WDATA[5:0];
            end
            if (wr_tlow) begin
                tag_low_q <= WDATA;
            end
            if (wr_thigh) begin
                tag_high_q <= WDATA;
            end
            if (wr_border) begin
                border_q <= WDATA;
            end
        end
    end

    // Wake bit; soft reset clears it first, else a fresh write beats waking.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wake_q <= 1'b0;
        end else if (soft_rst_q) begin
            wake_q <= 1'b0;
        end else if (wr_wake && WDATA[mfvc_pkg::WAKE_BIT]) begin
            wake_q <= 1'b1;
        end else if (AWAKE) begin
            wake_q <= 1'b0;
        end
    end
    assign WAKE_REQUEST = wake_q;

    // End page tracks clean transmissions; stop or soft reset zero it.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            end_page_q <= mfvc_pkg::RST_END_PAGE;
        end else if (STOP_CMD || soft_rst_q) begin
            end_page_q <= mfvc_pkg::RST_END_PAGE;
        end else if (TX_DONE_OK) begin
            end_page_q <= TX_END_PAGE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Duplex: the internal PHY decides alone; else either request forces full.
    always_comb begin
        if (!mcfg_q[mfvc_pkg::MC_MEDIA_BIT]) begin
            duplex_full = PHY_FULL_DUPLEX;
        end else begin
            duplex_full = mcfg_q[mfvc_pkg::MC_DUPLEX_BIT] | TX_CONFIG_FULL;
        end
    end

    // Back pressure stops after the jam limit unless leakage is disabled.
    always_comb begin
        BACKPRESSURE_ACTIVE = flow_q[mfvc_pkg::FC_BP_BIT] && !duplex_full;
        if (!mcfg_q[mfvc_pkg::MC_LEAK_DIS_BIT] && COLLISION_RUN >= jam_q) begin
            BACKPRESSURE_ACTIVE = 1'b0;
        end
    end

    assign FLOW_CTRL_ENABLE      = flow_q[mfvc_pkg::FC_ENABLE_BIT];
    assign HIGH_WATER_FREE_PAGES = flow_q[5:0];
    assign MAC_DUPLEX            = duplex_full;
    assign BACK_TO_BACK_TX       = mcfg_q[mfvc_pkg::MC_B2B_BIT];
    assign MEDIA_SELECT          = mcfg_q[mfvc_pkg::MC_MEDIA_BIT];
    assign FRAME_URGENCY_CLASS   = tag_high_q[7:5];
    assign CANONICAL_FORMAT_FLAG = tag_high_q[4];
    assign BIG_ENDIAN            = |border_q;

    ////////////////////////////////////////////////////////////////////////
    // Test-mode back-off shaping.
    mfvc_backoff u_backoff (
        .capture_effect_test (mcfg_q[mfvc_pkg::MC_CAPTURE_BIT]),
        .short_backoff_test  (mcfg_q[mfvc_pkg::MC_SHORT_BIT]),
        .zero_backoff_test   (mcfg_q[mfvc_pkg::MC_ZERO_BIT]),
        .attempt             (BO_ATTEMPT),
        .random_slots        (BO_RANDOM),
        .slots               (BO_SLOTS)
    );

    // Receive tag filter.
    mfvc_tag_filter u_filter (
        .enable       (mcfg_q[mfvc_pkg::MC_TAG_BIT]),
        .frame_tagged (RX_TAGGED),
        .tag_type     (RX_TAG_TYPE),
        .frame_id     (RX_TAG_ID),
        .prog_id      ({tag_high_q[3:0], tag_low_q}),
        .accept       (RX_ACCEPT)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux; write-only offsets read as zero.
    always_comb begin
        case (ADDR)
            mfvc_pkg::OFF_FLOW_CTRL:  rdata_d = flow_q;
            mfvc_pkg::OFF_MAC_CONFIG: rdata_d = {duplex_full, mcfg_q[6:0]};
            mfvc_pkg::OFF_TAG_LOW:    rdata_d = {TX_QUEUE_FULL, end_page_q};
            default:                  rdata_d = 8'h00;
        endcase
    end

    // Read data is registered: valid the cycle after the read strobe.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD_STB) begin
            RDATA <= rdata_d;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/mfvc_regs_sva.sv */
// Port checker for the MAC configuration register group.
`default_nettype none
module mfvc_regs_chk (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [4:0] ADDR,
    input wire logic       WR_STB,
    input wire logic       RD_STB,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic       TX_CONFIG_FULL,
    input wire logic       PHY_FULL_DUPLEX,
    input wire logic       TX_QUEUE_FULL,
    input wire logic       FLOW_CTRL_ENABLE,
    input wire logic [5:0] HIGH_WATER_FREE_PAGES,
    input wire logic       MAC_DUPLEX,
    input wire logic       BACKPRESSURE_ACTIVE,
    input wire logic       MEDIA_SELECT,
    input wire logic       BIG_ENDIAN,
    input wire logic       WAKE_REQUEST,
    input wire logic       SOFT_RESET
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////
    // A write in the soft-reset cycle is lost, so those are excluded.
    chk_flow_write: assert property (
        WR_STB && ADDR == 5'h1a && !SOFT_RESET |=>
        FLOW_CTRL_ENABLE == $past(WDATA[7]) &&
        HIGH_WATER_FREE_PAGES == $past(WDATA[5:0]))
        else $error("flow write not applied");
    // A second read right behind the first stretches the pulse legally.
    chk_soft_pulse: assert property (
        RD_STB && ADDR == 5'h1f ##1 !(RD_STB && ADDR == 5'h1f) |->
        SOFT_RESET ##1 !SOFT_RESET)
        else $error("soft reset pulse wrong");
    chk_soft_defaults: assert property (
        SOFT_RESET |=> !FLOW_CTRL_ENABLE && !BIG_ENDIAN &&
        HIGH_WATER_FREE_PAGES == 6'h07 && !WAKE_REQUEST)
        else $error("defaults missing after soft reset");
    chk_duplex_phy: assert property (
        !MEDIA_SELECT |-> MAC_DUPLEX == PHY_FULL_DUPLEX)
        else $error("internal duplex wrong");
    chk_duplex_tx: assert property (
        MEDIA_SELECT && TX_CONFIG_FULL |-> MAC_DUPLEX)
        else $error("transmit duplex ignored");
    chk_bp_full: assert property (
        MAC_DUPLEX |-> !BACKPRESSURE_ACTIVE)
        else $error("back pressure in full duplex");
    chk_queue_read: assert property (
        RD_STB && ADDR == 5'h1c && !SOFT_RESET |=>
        RDATA[7] == $past(TX_QUEUE_FULL))
        else $error("queue full bit wrong");
    chk_byte_order: assert property (
        WR_STB && ADDR == 5'h1e && !SOFT_RESET |=>
        BIG_ENDIAN == ($past(WDATA) != 8'h00))
        else $error("byte order wrong");
    chk_wake_set: assert property (
        WR_STB && ADDR == 5'h1f && WDATA[0] && !SOFT_RESET |=>
        WAKE_REQUEST)
        else $error("wake not set");
    cov_soft: cover property (SOFT_RESET);
    cov_ext_full: cover property (MEDIA_SELECT && MAC_DUPLEX);
    cov_bp: cover property (BACKPRESSURE_ACTIVE);
endmodule
bind mfvc_regs mfvc_regs_chk i_chk (.CLK(CLK), .RST(RST),
    .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .WDATA(WDATA),
    .RDATA(RDATA), .TX_CONFIG_FULL(TX_CONFIG_FULL),
    .PHY_FULL_DUPLEX(PHY_FULL_DUPLEX), .TX_QUEUE_FULL(TX_QUEUE_FULL),
    .FLOW_CTRL_ENABLE(FLOW_CTRL_ENABLE), .MAC_DUPLEX(MAC_DUPLEX),
    .HIGH_WATER_FREE_PAGES(HIGH_WATER_FREE_PAGES),
    .BACKPRESSURE_ACTIVE(BACKPRESSURE_ACTIVE), .BIG_ENDIAN(BIG_ENDIAN),
    .MEDIA_SELECT(MEDIA_SELECT), .WAKE_REQUEST(WAKE_REQUEST),
    .SOFT_RESET(SOFT_RESET));
`default_nettype wire

/* File: testbench/mfvc_host_model.sv */
// Host model that drives the byte-wide register port.
`default_nettype none
module mfvc_host_model (
    input  wire logic       CLK,
    output logic      [4:0] ADDR,
    output logic            WR_STB,
    output logic            RD_STB,
    output logic      [7:0] WDATA,
    input  wire logic [7:0] RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    // Port idles with both strobes low.
    initial begin
        ADDR = 5'h00;
        WR_STB = 1'b0;
        RD_STB = 1'b0;
        WDATA = 8'h00;
    end
    // One write; idle data is scrambled so no stale byte looks valid.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge CLK);
        WR_STB <= 1'b0;
        WDATA <= ~d;
        #1;
    endtask
    // One read; data is taken the cycle after the strobe.
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge CLK);
        RD_STB <= 1'b0;
        #1;
        d = RDATA;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_mac_flow_vlan_config_regs.sv */
// Self-checking bench for the MAC configuration register group.
`default_nettype none
module tb_mac_flow_vlan_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, tcf, pfd, tqf, tdo, stop_command, awk, rtg, wrs, rds, acc;
    logic fce, bpa, dpx, b2b, med, cff, ben, wrq, srs;
    logic [4:0] adr, att;
    logic [7:0] wd, rdt, d;
    logic [6:0] tep;
    logic [5:0] col, hwp;
    logic [9:0] brn, bos;
    logic [11:0] rid;
    logic [2:0] urg;
    logic [15:0] rtt;
    int n_fail = 0;
    int check_count = 0;
    mfvc_host_model i_host (.CLK(clk), .ADDR(adr), .WR_STB(wrs),
        .RD_STB(rds), .WDATA(wd), .RDATA(rdt));
    mfvc_regs i_dut (.CLK(clk), .RST(rst), .ADDR(adr), .WR_STB(wrs),
        .RD_STB(rds), .WDATA(wd), .RDATA(rdt), .TX_CONFIG_FULL(tcf),
        .PHY_FULL_DUPLEX(pfd), .TX_QUEUE_FULL(tqf), .TX_DONE_OK(tdo),
        .TX_END_PAGE(tep), .STOP_CMD(stop_command), .AWAKE(awk),
        .COLLISION_RUN(col), .BO_ATTEMPT(att), .BO_RANDOM(brn),
        .RX_TAGGED(rtg), .RX_TAG_TYPE(rtt), .RX_TAG_ID(rid),
        .RX_ACCEPT(acc), .BO_SLOTS(bos), .FLOW_CTRL_ENABLE(fce),
        .BACKPRESSURE_ACTIVE(bpa), .HIGH_WATER_FREE_PAGES(hwp),
        .MAC_DUPLEX(dpx), .BACK_TO_BACK_TX(b2b), .MEDIA_SELECT(med),
        .FRAME_URGENCY_CLASS(urg), .CANONICAL_FORMAT_FLAG(cff),
        .BIG_ENDIAN(ben), .WAKE_REQUEST(wrq), .SOFT_RESET(srs));
    ////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Present one receive frame and judge the filter.
    task automatic frame(input logic t, input logic [11:0] i,
                         input logic e);
        @(posedge clk);
        rtg <= t;
        rid <= i;
        #1;
        chk(acc, e);
    endtask
    // Present one collision number and judge the slot count.
    task automatic bo(input logic [4:0] a, input logic [9:0] e);
        @(posedge clk);
        att <= a;
        #1;
        chk(bos, e);
    endtask
    task automatic t_flow();
        i_host.wr(5'h1a, 8'hc5);
        chk({fce, hwp}, 7'h45);
        @(posedge clk);
        col <= 6'h18;
        #1;
        chk(bpa, 1'b1);
        @(posedge clk);
        col <= 6'h19;
        #1;
        chk(bpa, 1'b0);
        i_host.wr(5'h1b, 8'h40);
        chk(bpa, 1'b1);
        i_host.wr(5'h1b, 8'h00);
        i_host.wr(5'h17, 8'h03);
        @(posedge clk);
        col <= 6'h03;
        #1;
        chk(bpa, 1'b0);
        @(posedge clk);
        col <= 6'h00;
        pfd <= 1'b1;
        #1;
        chk(bpa, 1'b0);
        i_host.wr(5'h1a, 8'h05);
        chk(fce, 1'b0);
        $display("test flow done");
    endtask
    task automatic t_duplex();
        i_host.wr(5'h1b, 8'h80);
        @(posedge clk);
        tcf <= 1'b1;
        pfd <= 1'b0;
        #1;
        chk(dpx, 1'b0);
        i_host.rd(5'h1b, d);
        chk(d, 8'h00);
        i_host.wr(5'h1b, 8'h10);
        chk({med, dpx}, 2'b11);
        @(posedge clk);
        tcf <= 1'b0;
        #1;
        chk(dpx, 1'b0);
        i_host.wr(5'h1b, 8'h90);
        i_host.rd(5'h1b, d);
        chk(d, 8'h90);
        $display("test duplex done");
    endtask
    task automatic t_tag();
        i_host.wr(5'h1c, 8'h34);
        i_host.wr(5'h1d, 8'hb5);
        chk({urg, cff}, 4'hb);
        i_host.wr(5'h1b, 8'h08);
        frame(1'b1, 12'h534, 1'b1);
        frame(1'b1, 12'h434, 1'b0);
        frame(1'b1, 12'h000, 1'b1);
        frame(1'b0, 12'h534, 1'b0);
        // Another tag type is not compared, so a foreign id still passes.
        @(posedge clk);
        rtt <= 16'h88a8;
        frame(1'b1, 12'h434, 1'b1);
        @(posedge clk);
        rtt <= 16'h8100;
        i_host.wr(5'h1b, 8'h00);
        frame(1'b0, 12'h123, 1'b1);
        $display("test tag done");
    endtask
    task automatic t_backoff();
        @(posedge clk);
        brn <= 10'h3ff;
        i_host.wr(5'h1b, 8'h01);
        bo(5'h01, 10'h000);
        i_host.wr(5'h1b, 8'h02);
        bo(5'h05, 10'h003);
        i_host.wr(5'h1b, 8'h04);
        bo(5'h01, 10'h002);
        bo(5'h02, 10'h000);
        bo(5'h03, 10'h3ff);
        $display("test backoff done");
    endtask
    task automatic t_queue();
        @(posedge clk);
        tqf <= 1'b1;
        tep <= 7'h45;
        tdo <= 1'b1;
        @(posedge clk);
        tdo <= 1'b0;
        i_host.rd(5'h1c, d);
        chk(d, 8'hc5);
        @(posedge clk);
        stop_command <= 1'b1;
        @(posedge clk);
        stop_command <= 1'b0;
        tqf <= 1'b0;
        i_host.rd(5'h1c, d);
        chk(d, 8'h00);
        $display("test queue done");
    endtask
    task automatic t_wake();
        i_host.wr(5'h1e, 8'h20);
        chk(ben, 1'b1);
        i_host.wr(5'h1e, 8'h00);
        chk(ben, 1'b0);
        i_host.wr(5'h1e, 8'h01);
        chk(ben, 1'b1);
        i_host.wr(5'h1f, 8'h01);
        chk(wrq, 1'b1);
        @(posedge clk);
        awk <= 1'b1;
        @(posedge clk);
        awk <= 1'b0;
        #1;
        chk(wrq, 1'b0);
        i_host.wr(5'h1a, 8'h80);
        i_host.wr(5'h1b, 8'h20);
        chk(b2b, 1'b1);
        i_host.rd(5'h1f, d);
        chk(srs, 1'b1);
        @(posedge clk);
        #1;
        chk({srs, fce, ben, b2b, hwp}, 10'h007);
        // Let the soft-reset assertions complete before the run ends.
        repeat (2) @(posedge clk);
        $display("test wake and soft reset done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // A hung bus task would otherwise stall the run forever.
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        {rst, tcf, pfd, tqf, tdo, stop_command, awk, rtg} = 8'h80;
        {att, brn, rid, tep, col} = 40'h0;
        rtt = 16'h8100;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({fce, bpa, b2b, med, ben, hwp}, 11'h007);
        t_flow();
        t_duplex();
        t_tag();
        t_backoff();
        t_queue();
        t_wake();
        conclude();
    end
endmodule
`default_nettype wire
